/* File: hw/swpm_regs.vh */
// Register offsets, field positions, reset values and timing for switch port
`ifndef SWPM_REGS_VH
`define SWPM_REGS_VH
`define SWPM_NSW 8
`define SWPM_NIO 8
`define SWPM_ADDR_W 4
// Register offsets
`define SWPM_OFF_PU 4'h0
`define SWPM_OFF_PD 4'h1
`define SWPM_OFF_ROW 4'h2
`define SWPM_OFF_CFG 4'h3
`define SWPM_OFF_IOEN 4'h4
`define SWPM_OFF_IOIRQ 4'h5
`define SWPM_OFF_EDGE 4'h6
`define SWPM_OFF_ADC 4'h7
`define SWPM_OFF_PWM 4'h8
`define SWPM_OFF_ODOUT 4'h9
`define SWPM_OFF_SWIN 4'ha
`define SWPM_OFF_IOIN 4'hb
`define SWPM_OFF_STAT 4'hc
`define SWPM_OFF_CLR 4'hd
`define SWPM_OFF_IEN 4'he
`define SWPM_OFF_SLEEP 4'hf
// Central source config fields
`define SWPM_CFG_PU_RED 1
`define SWPM_CFG_PD_RED 2
// Status fields
`define SWPM_ST_LWAKE 0
`define SWPM_ST_WERR 1
`define SWPM_ST_IOIRQ 2
// Edge register: low nibble rising enables, high falling, per io pair
`define SWPM_RST_BYTE 8'h00
// Timing, in core cycles
`define SWPM_SLEEP_CNT 16'd1000
`define SWPM_FILT_CNT 16'd20
`endif

/* File: hw/swpm_sync.v */
// Three-stage synchroniser with agreement check for pin inputs
`timescale 1ns/1ps
module swpm_sync #(
  parameter W = 8
) (
  input wire core_clk_i,
  input wire reset_n_i,
  input wire [W-1:0] async_i,
  output reg [W-1:0] sync_o
);
  reg [W-1:0] s1_reg; // First stage, read only by second
  reg [W-1:0] s2_reg; // Second stage
  reg [W-1:0] s3_reg; // Third stage

  // Change is accepted once stage two and three agree
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_reg <= {W{1'b0}};
      s2_reg <= {W{1'b0}};
      s3_reg <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end else begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // Hold the old value while the stages disagree, else take stage two
      sync_o <= (sync_o & (s2_reg ^ s3_reg)) |
        (s2_reg & ~(s2_reg ^ s3_reg));
    end
  end
endmodule

/* File: hw/swpm_top.v */
// Switch and IO port mode control with sleep wake-up detection
//
// Notes on behaviour
// - Three path bits select switch pin mode.
// - Latch path switches on sleep command rise.
// - Sleep counter blocks wake-ups until expiry.
// - Mismatch at expiry wakes, sets error flag.
// - Filtered switch change sets local wake flag.
// - Sleep modes: open, pull-up, pull-down, row.
// - Any IO selectable as converter channel.
// - IO interrupt on rising, falling or both.
// - PWM routed to IO only when open-drain is off.
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "swpm_regs.vh"
module swpm_top #(
  parameter [15:0] SLEEP_CYCLES = `SWPM_SLEEP_CNT,
  parameter [15:0] FILTER_CYCLES = `SWPM_FILT_CNT
) (
  input wire core_clk_i,
  input wire reset_n_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire [7:0] pullup_comparator_result_i,
  input wire [7:0] pulldown_comparator_result_i,
  input wire [7:0] io_pin_i,
  input wire [7:0] pwm_i,
  output reg [7:0] pullup_path_switch_o,
  output reg [7:0] pulldown_path_switch_o,
  output reg [7:0] row_path_switch_o,
  output reg pullup_reduce_diag_o,
  output reg pulldown_reduce_diag_o,
  output reg [7:0] io_od_drive_o,
  output reg [7:0] converter_select_o,
  output reg sleep_active_o,
  output reg wake_o,
  output reg irq_o
);
  // Software registers
  reg [7:0] pin_pullup_connect_reg; // Pull-up path enables
  reg [7:0] pin_pulldown_connect_reg; // Pull-down path enables
  reg [7:0] pin_row_connect_reg; // Row path enables
  reg [1:0] central_source_config_reg; // Reduce bits
  reg [7:0] io_en_reg; // IO digital/open-drain enable
  reg [7:0] io_irq_reg; // IO interrupt input select
  reg [7:0] edge_reg; // [3:0] rising, [7:4] falling, io pairs
  reg [7:0] converter_control_reg; // Converter channel select, one bit per IO, any mix
  reg [7:0] pwm_sel_reg; // PWM routing
  reg [7:0] od_out_reg; // Open-drain output data
  reg [7:0] status_reg; // Sticky events
  reg [7:0] irq_en_reg; // Interrupt enables
  reg sleep_cmd_reg; // Sleep entry command bit
  reg sleep_cmd_d_reg; // Delayed command for edge
  // Sleep state machine: ACTIVE follows software, SETTLE counts down
  // the sleep counter with wake-ups masked, WATCH filters changes.
  // A wake of either kind clears the command bit, so software must
  // write it again to go back to sleep.
  localparam [2:0] ST_ACTIVE = 3'b001;
  localparam [2:0] ST_SETTLE = 3'b010;
  localparam [2:0] ST_WATCH = 3'b100;
  reg [2:0] state_reg;
  reg [15:0] cnt_reg; // Sleep counter
  reg [15:0] filt_reg; // Wake filter counter
  reg [7:0] ref_pu_reg; // Latched path switches
  reg [7:0] ref_pd_reg;
  reg [7:0] ref_row_reg;
  reg [7:0] ref_in_reg; // Latched switch inputs
  reg [7:0] io_prev_reg; // Previous IO levels for edges
  wire [7:0] pu_s; // Synchronised comparator results
  wire [7:0] pd_s;
  wire [7:0] io_s;
  wire [7:0] switch_digital_input;
  wire [7:0] io_rise;
  wire [7:0] io_fall;
  wire io_event;
  wire sleep_rise;
  wire sw_change;
  wire werr_set; // Mismatch seen as the sleep count runs out
  wire lwake_set; // Change outlasted the wake filter
  wire [2:0] ev_set; // Events this cycle, in status bit order

  // Comparator results and IO levels come from the analog side and
  // other supplies, so each passes its own three-flop synchroniser.
  // The cost is four cycles of latency on every pin reading, which
  // the wake filter and the sleep counter both absorb.
  swpm_sync #(.W(8)) u_sync_pu (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .async_i(pullup_comparator_result_i),
    .sync_o(pu_s)
  );
  swpm_sync #(.W(8)) u_sync_pd (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .async_i(pulldown_comparator_result_i),
    .sync_o(pd_s)
  );
  swpm_sync #(.W(8)) u_sync_io (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .async_i(io_pin_i),
    .sync_o(io_s)
  );

  // Edge mask expander: bit pair per nibble bit covers two IO pins
  function [7:0] swpm_pairs;
    input [3:0] n;
    begin
      swpm_pairs = {n[3], n[3], n[2], n[2], n[1], n[1], n[0], n[0]};
    end
  endfunction

  // Select comparator from active path: row reads pull-up side
  assign switch_digital_input =
    (pin_pulldown_connect_reg & pd_s) | (~pin_pulldown_connect_reg & pu_s);
  // IO edge detection on interrupt-enabled pins
  assign io_rise = io_s & ~io_prev_reg & io_en_reg & io_irq_reg;
  assign io_fall = ~io_s & io_prev_reg & io_en_reg & io_irq_reg;
  assign io_event = |((io_rise & swpm_pairs(edge_reg[3:0])) |
    (io_fall & swpm_pairs(edge_reg[7:4])));
  assign sleep_rise = sleep_cmd_reg & ~sleep_cmd_d_reg;
  // Only switches with a wake path take part; open pins never wake
  assign sw_change = |((switch_digital_input ^ ref_in_reg) &
    (ref_pu_reg | ref_pd_reg | ref_row_reg));

  // Event strobes are decoded from the current state so that the
  // status update below sees them in the same cycle as the transition
  assign werr_set = (state_reg == ST_SETTLE) &&
    (cnt_reg <= 16'h0001) && sw_change;
  assign lwake_set = (state_reg == ST_WATCH) && sw_change &&
    (filt_reg >= FILTER_CYCLES);
  assign ev_set = {io_event, werr_set, lwake_set};

  // Register writes and sleep sequencing
  // One process owns every software and sleep register so that a hardware clear of the
  // sleep command takes priority over a software write in one cycle.
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_pullup_connect_reg <= `SWPM_RST_BYTE;
      pin_pulldown_connect_reg <= `SWPM_RST_BYTE;
      pin_row_connect_reg <= `SWPM_RST_BYTE;
      central_source_config_reg <= 2'h0;
      io_en_reg <= `SWPM_RST_BYTE;
      io_irq_reg <= `SWPM_RST_BYTE;
      edge_reg <= `SWPM_RST_BYTE;
      converter_control_reg <= `SWPM_RST_BYTE;
      pwm_sel_reg <= `SWPM_RST_BYTE;
      od_out_reg <= `SWPM_RST_BYTE;
      irq_en_reg <= `SWPM_RST_BYTE;
      status_reg <= `SWPM_RST_BYTE;
      sleep_cmd_reg <= 1'b0;
      sleep_cmd_d_reg <= 1'b0;
      state_reg <= ST_ACTIVE;
      cnt_reg <= 16'h0000;
      filt_reg <= 16'h0000;
      ref_pu_reg <= 8'h00;
      ref_pd_reg <= 8'h00;
      ref_row_reg <= 8'h00;
      ref_in_reg <= 8'h00;
      io_prev_reg <= 8'h00;
    end else begin
      sleep_cmd_d_reg <= sleep_cmd_reg;
      io_prev_reg <= io_s;
      if (wr_i) begin
        case (addr_i)
          `SWPM_OFF_PU: pin_pullup_connect_reg <= wdata_i;
          `SWPM_OFF_PD: pin_pulldown_connect_reg <= wdata_i;
          `SWPM_OFF_ROW: pin_row_connect_reg <= wdata_i;
          `SWPM_OFF_CFG: begin
            central_source_config_reg <= {wdata_i[`SWPM_CFG_PD_RED],
              wdata_i[`SWPM_CFG_PU_RED]};
          end
          `SWPM_OFF_IOEN: io_en_reg <= wdata_i;
          `SWPM_OFF_IOIRQ: io_irq_reg <= wdata_i;
          `SWPM_OFF_EDGE: edge_reg <= wdata_i;
          `SWPM_OFF_ADC: converter_control_reg <= wdata_i;
          `SWPM_OFF_PWM: pwm_sel_reg <= wdata_i;
          `SWPM_OFF_ODOUT: od_out_reg <= wdata_i;
          `SWPM_OFF_IEN: irq_en_reg <= wdata_i;
          `SWPM_OFF_SLEEP: sleep_cmd_reg <= wdata_i[0];
          default: begin
          end
        endcase
      end
      // Sleep sequencing
      case (state_reg)
        ST_ACTIVE: begin
          // Paths and inputs are frozen here as the wake reference
          if (sleep_rise) begin
            ref_pu_reg <= pin_pullup_connect_reg;
            ref_pd_reg <= pin_pulldown_connect_reg;
            ref_row_reg <= pin_row_connect_reg;
            ref_in_reg <= switch_digital_input;
            cnt_reg <= SLEEP_CYCLES;
            state_reg <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          // Wake conditions are ignored while counting down
          if (cnt_reg > 16'h0001) begin
            cnt_reg <= cnt_reg - 16'h0001;
          end else if (sw_change) begin
            sleep_cmd_reg <= 1'b0;
            state_reg <= ST_ACTIVE;
          end else begin
            filt_reg <= 16'h0000;
            state_reg <= ST_WATCH;
          end
        end
        ST_WATCH: begin
          // Change must persist past the filter time
          if (!sw_change) begin
            filt_reg <= 16'h0000;
          end else if (filt_reg >= FILTER_CYCLES) begin
            sleep_cmd_reg <= 1'b0;
            state_reg <= ST_ACTIVE;
          end else begin
            filt_reg <= filt_reg + 16'h0001;
          end
        end
        default: state_reg <= ST_ACTIVE;
      endcase
      // Set wins over a clear in the same cycle,
      // so an event never slips past a software clear of the same bit
      if (wr_i && addr_i == `SWPM_OFF_CLR) begin
        status_reg <= (status_reg & ~wdata_i) | {5'h00, ev_set};
      end else begin
        status_reg <= status_reg | {5'h00, ev_set};
      end
    end
  end

  // Every output is a flop, so software writes show at the pins two
  // cycles after the strobe: one for the register, one for the flop.
  // Outputs and read data, all registered
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= 8'h00;
      pullup_path_switch_o <= 8'h00;
      pulldown_path_switch_o <= 8'h00;
      row_path_switch_o <= 8'h00;
      pullup_reduce_diag_o <= 1'b0;
      pulldown_reduce_diag_o <= 1'b0;
      io_od_drive_o <= 8'h00;
      converter_select_o <= 8'h00;
      sleep_active_o <= 1'b0;
      wake_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      // Sleep holds latched paths so software cannot disturb them
      if (state_reg != ST_ACTIVE) begin
        pullup_path_switch_o <= ref_pu_reg;
        pulldown_path_switch_o <= ref_pd_reg;
        row_path_switch_o <= ref_row_reg;
      end else begin
        pullup_path_switch_o <= pin_pullup_connect_reg;
        pulldown_path_switch_o <= pin_pulldown_connect_reg;
        row_path_switch_o <= pin_row_connect_reg;
      end
      // Only one reduce bit at a time forms a diagnosis mode
      pullup_reduce_diag_o <= central_source_config_reg[0] &
        ~central_source_config_reg[1];
      pulldown_reduce_diag_o <= central_source_config_reg[1] &
        ~central_source_config_reg[0];
      // Pin driven low when open-drain selected and its output data bit is 0; PWM and open-drain both gated by row path
      io_od_drive_o <= (pwm_sel_reg & pin_row_connect_reg & ~io_en_reg &
        ~pwm_i) |
        (~pwm_sel_reg & pin_row_connect_reg & io_en_reg & ~od_out_reg);
      converter_select_o <= converter_control_reg;
      sleep_active_o <= (state_reg != ST_ACTIVE);
      wake_o <= |(status_reg[1:0]);
      irq_o <= |(status_reg & irq_en_reg);
      rdata_o <= 8'h00;
      if (rd_i) begin
        case (addr_i)
          `SWPM_OFF_PU: rdata_o <= pin_pullup_connect_reg;
          `SWPM_OFF_PD: rdata_o <= pin_pulldown_connect_reg;
          `SWPM_OFF_ROW: rdata_o <= pin_row_connect_reg;
          `SWPM_OFF_CFG: rdata_o <= {5'h00, central_source_config_reg, 1'b0};
          `SWPM_OFF_IOEN: rdata_o <= io_en_reg;
          `SWPM_OFF_IOIRQ: rdata_o <= io_irq_reg;
          `SWPM_OFF_EDGE: rdata_o <= edge_reg;
          `SWPM_OFF_ADC: rdata_o <= converter_control_reg;
          `SWPM_OFF_PWM: rdata_o <= pwm_sel_reg;
          `SWPM_OFF_ODOUT: rdata_o <= od_out_reg;
          `SWPM_OFF_SWIN: rdata_o <= switch_digital_input;
          `SWPM_OFF_IOIN: rdata_o <= io_s;
          `SWPM_OFF_STAT: rdata_o <= status_reg;
          `SWPM_OFF_IEN: rdata_o <= irq_en_reg;
          `SWPM_OFF_SLEEP: rdata_o <= {7'h00, sleep_cmd_reg};
          default: rdata_o <= 8'h00;
        endcase
      end
    end
  end
endmodule

/* File: dv/swpm_top_asserts.sv */
// Port-level checks for the switch port and wake block
`timescale 1ns/1ps
module swpm_chk #(
  parameter [15:0] SLEEP_CYCLES = 16'd1000
) (
  input wire core_clk_i,
  input wire reset_n_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire [7:0] pullup_path_switch_o,
  input wire [7:0] pulldown_path_switch_o,
  input wire [7:0] row_path_switch_o,
  input wire pullup_reduce_diag_o,
  input wire pulldown_reduce_diag_o,
  input wire [7:0] io_od_drive_o,
  input wire [7:0] converter_select_o,
  input wire sleep_active_o,
  input wire wake_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Status clear strobe, seen two cycles before wake may drop
  wire clr_wr = wr_i && addr_i == 4'hd;
  // Cycles in the sleep sequence; saturates so it never wraps
  reg [15:0] slp_cnt;
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) slp_cnt <= 16'h0000;
    else if (!sleep_active_o) slp_cnt <= 16'h0000;
    else if (slp_cnt != 16'hffff) slp_cnt <= slp_cnt + 16'h0001;
  end
  a_rdata_idle:
    assert property (rdata_o != 8'h00 |-> $past(rd_i))
    else $error("read data outside read slot");
  a_pu_write:
    assert property (wr_i && addr_i == 4'h0 |-> ##2 (sleep_active_o ||
      pullup_path_switch_o == $past(wdata_i, 2)))
    else $error("pull-up paths");
  a_pd_write:
    assert property (wr_i && addr_i == 4'h1 |-> ##2 (sleep_active_o ||
      pulldown_path_switch_o == $past(wdata_i, 2)))
    else $error("pull-down");
  a_diag_cfg:
    assert property (wr_i && addr_i == 4'h3 |-> ##2
      {pulldown_reduce_diag_o, pullup_reduce_diag_o} ==
      {$past(wdata_i[2] & ~wdata_i[1], 2),
      $past(wdata_i[1] & ~wdata_i[2], 2)})
    else $error("diagnosis reduce bits");
  a_diag_excl:
    assert property (!(pullup_reduce_diag_o && pulldown_reduce_diag_o))
    else $error("both sources reduced");
  a_conv_write:
    assert property (wr_i && addr_i == 4'h7 |-> ##2
      converter_select_o == $past(wdata_i, 2))
    else $error("converter select");
  a_od_row:
    assert property ((io_od_drive_o & ~row_path_switch_o &
      ~$past(row_path_switch_o)) == 8'h00) else $error("drive without row");
  a_early_wake:
    assert property ($rose(wake_o) |-> slp_cnt >= SLEEP_CYCLES - 16'd2)
    else $error("wake before sleep count");
  a_wake_sticky:
    assert property (wake_o && !clr_wr && !$past(clr_wr) |=> wake_o)
    else $error("wake dropped uncleared");
  a_wake_ends:
    assert property ($rose(wake_o) |-> ##[0:2] !sleep_active_o)
    else $error("sleep kept after wake");
endmodule

/* File: dv/swpm_sw_model.sv */
// External contacts seen through the chosen source paths
`timescale 1ns/1ps
module swpm_sw_model (
  input wire [7:0] closed_i,
  input wire [7:0] pu_path_i,
  input wire [7:0] pd_path_i,
  input wire [7:0] row_path_i,
  output wire [7:0] pu_cmp_o,
  output wire [7:0] pd_cmp_o
);
  // A pin with no source attached floats and reads as open
  assign pu_cmp_o = closed_i & (pu_path_i | row_path_i);
  assign pd_cmp_o = closed_i & pd_path_i;
endmodule

/* File: dv/swpm_top_bench.sv */
// Self-checking bench for the switch port and wake block
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
  n_mismatch++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); \
  end end
module swpm_top_bench;
  localparam [15:0] SLP = 16'd16; // Short counts keep the run brief
  localparam [15:0] FLT = 16'd4;
  reg core_clk_i = 1'b0;
  reg reset_n_i = 1'b0;
  reg [3:0] addr_i = 4'h0;
  reg [7:0] wdata_i = 8'h00;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg [7:0] io_pin_i = 8'h00;
  reg [7:0] pwm_i = 8'h00;
  reg [7:0] sw_closed = 8'h00; // Contact state of the switches
  wire [7:0] rdata_o, pullup_comparator_result_i;
  wire [7:0] pulldown_comparator_result_i, io_od_drive_o;
  wire [7:0] pullup_path_switch_o, pulldown_path_switch_o;
  wire [7:0] row_path_switch_o, converter_select_o;
  wire pullup_reduce_diag_o, pulldown_reduce_diag_o;
  wire sleep_active_o, wake_o, irq_o;
  integer n_mismatch = 0;
  integer n_compared = 0;
  integer cyc = 0;
  integer i;
  always #2.5 core_clk_i = ~core_clk_i;
  swpm_top #(.SLEEP_CYCLES(SLP), .FILTER_CYCLES(FLT)) uut (.*);
  swpm_sw_model sw (.closed_i(sw_closed), .pu_path_i(pullup_path_switch_o),
    .pd_path_i(pulldown_path_switch_o), .row_path_i(row_path_switch_o),
    .pu_cmp_o(pullup_comparator_result_i),
    .pd_cmp_o(pulldown_comparator_result_i));
  // Stimulus moves on the rising edge; outputs are read at the falling one
  task tick(input integer n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task look;
    @(negedge core_clk_i);
  endtask
  task settle(input integer n);
    tick(n);
    look;
  endtask
  task wr(input [3:0] a, input [7:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input [3:0] a, input [7:0] e);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    look;
    `CHK(rdata_o, e)
  endtask
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Cuts a hang short
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      end_sim;
    end
  end
  initial begin
    tick(8);
    reset_n_i <= 1'b1;
    wr(4'h0, 8'h5a);
    wr(4'h1, 8'h81);
    wr(4'h2, 8'h24);
    wr(4'h7, 8'hc3);
    settle(2);
    `CHK(pullup_path_switch_o, 8'h5a)
    `CHK({pulldown_path_switch_o, row_path_switch_o}, 16'h8124)
    `CHK(converter_select_o, 8'hc3)
    rd(4'h0, 8'h5a);
    rd(4'h7, 8'hc3);
    rd(4'hd, 8'h00);
    for (i = 0; i < 4; i++) begin
      wr(4'h3, 8'(i << 1));
      settle(2);
      `CHK(pullup_reduce_diag_o, i == 1)
      `CHK(pulldown_reduce_diag_o, i == 2)
    end
    $display("test registers done");
    wr(4'h0, 8'h00);
    wr(4'h2, 8'hff);
    wr(4'h4, 8'h00);
    wr(4'h8, 8'h0f);
    pwm_i <= 8'h05;
    settle(3);
    `CHK(io_od_drive_o, 8'h0a)
    wr(4'h4, 8'hf0);
    wr(4'h9, 8'h30);
    settle(3);
    `CHK(io_od_drive_o, 8'hca)
    wr(4'h2, 8'h0f);
    settle(3);
    `CHK(io_od_drive_o, 8'h0a)
    $display("test open drain done");
    wr(4'h2, 8'h00);
    wr(4'h4, 8'h01);
    wr(4'h5, 8'h01);
    wr(4'he, 8'h04);
    for (i = 0; i < 3; i++) begin
      wr(4'h6, i == 0 ? 8'h01 : i == 1 ? 8'h10 : 8'h11);
      wr(4'hd, 8'h07);
      io_pin_i <= 8'h01;
      settle(8);
      `CHK(irq_o, i != 1)
      wr(4'hd, 8'h04);
      io_pin_i <= 8'h00;
      settle(8);
      `CHK(irq_o, i != 0)
      wr(4'hd, 8'h04);
      settle(3);
      `CHK(irq_o, 1'b0)
    end
    wr(4'he, 8'h00);
    io_pin_i <= 8'h01;
    settle(8);
    `CHK(irq_o, 1'b0)
    rd(4'hc, 8'h04);
    rd(4'hb, 8'h01);
    wr(4'he, 8'h07);
    settle(3);
    `CHK(irq_o, 1'b1)
    wr(4'hd, 8'h07);
    settle(3);
    `CHK(irq_o, 1'b0)
    rd(4'hc, 8'h00);
    $display("test io interrupt done");
    // Only healthy contacts get a path before sleep
    wr(4'h0, 8'h01);
    wr(4'h1, 8'h02);
    sw_closed <= 8'h01;
    settle(8);
    rd(4'ha, 8'h01);
    wr(4'hf, 8'h01);
    tick(2);
    sw_closed <= 8'h00;
    look;
    `CHK(sleep_active_o, 1'b1)
    `CHK(pullup_path_switch_o, 8'h01)
    // Wake error must wait for the full sleep count
    settle(SLP - 1);
    `CHK(wake_o, 1'b0)
    settle(1);
    `CHK(wake_o, 1'b1)
    rd(4'hc, 8'h02);
    `CHK(irq_o, 1'b1)
    wr(4'hd, 8'h03);
    settle(3);
    `CHK(wake_o, 1'b0)
    $display("test wake error done");
    wr(4'hf, 8'h01);
    settle(SLP + 10);
    `CHK({wake_o, sleep_active_o}, 2'b01)
    // Software writes in sleep must not disturb the latched paths
    wr(4'h0, 8'hff);
    settle(3);
    `CHK(pullup_path_switch_o, 8'h01)
    tick(1);
    sw_closed <= 8'h02;
    tick(1);
    sw_closed <= 8'h00;
    settle(12);
    `CHK({wake_o, sleep_active_o}, 2'b01)
    tick(1);
    sw_closed <= 8'h02;
    settle(FLT + 4);
    `CHK(wake_o, 1'b0)
    settle(2);
    `CHK(wake_o, 1'b1)
    rd(4'hc, 8'h01);
    rd(4'ha, 8'h02);
    $display("test local wake done");
    end_sim;
  end
endmodule
bind swpm_top swpm_chk #(.SLEEP_CYCLES(SLEEP_CYCLES)) chk (.*);
